/* File: rtl/ssw_interval.sv */
`timescale 1ns/10ps
// ****************************************************************
// Interval counter: restarts while clr is high, done once it reaches limit
// ****************************************************************
module ssw_interval #(
    parameter int unsigned LIMIT = 16
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Control
    input  wire logic clr,
    input  wire logic run,
    // Status
    output logic      done
);
    localparam int W = $clog2(LIMIT + 1);
    localparam logic [W-1:0] LIM = W'(LIMIT);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    assign done     = (cnt_reg == LIM);
    assign cnt_next = clr ? '0 : ((run && !done) ? cnt_reg + W'(1) : cnt_reg);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule

/* File: rtl/ssw_pkg.sv */
package ssw_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned MCLK_HZ         = 250_000_000;
    localparam int unsigned MCLK_PERIOD_NS  = 4;
    localparam int unsigned RESET_STRETCH_MS = 200;
    localparam int unsigned WDOG_TIMEOUT_MS  = 1600;
    localparam int unsigned CE_HOLD_US       = 10;
    // Least times round up, never below one cycle
    localparam longint unsigned RESET_STRETCH_CYC =
        (longint'(RESET_STRETCH_MS) * 1_000_000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam longint unsigned WDOG_TIMEOUT_CYC =
        (longint'(WDOG_TIMEOUT_MS) * 1_000_000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam longint unsigned CE_HOLD_CYC =
        (longint'(CE_HOLD_US) * 1_000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic RST_N_INIT   = 1'b0;
    localparam logic WDOG_N_INIT  = 1'b1;
    localparam logic BACKUP_INIT  = 1'b0;
    localparam logic CE_OUT_INIT  = 1'b1;
    typedef enum logic [1:0] {SSW_CE_PASS, SSW_CE_HOLD, SSW_CE_BLOCK} ssw_ce_state_t;
endpackage

/* File: rtl/ssw_supervisor.sv */
`timescale 1ns/10ps
module ssw_supervisor
    import ssw_pkg::*;
#(
    parameter longint unsigned STRETCH_CYC = ssw_pkg::RESET_STRETCH_CYC,
    parameter longint unsigned WDOG_CYC    = ssw_pkg::WDOG_TIMEOUT_CYC,
    parameter longint unsigned CE_CYC      = ssw_pkg::CE_HOLD_CYC
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Supply compares, high when the supply is above the level
    input  wire logic vcc_above_reset,
    input  wire logic vcc_above_switchover,
    input  wire logic vcc_above_cell,
    input  wire logic vcc_above_early_supply_warning_n,
    input  wire logic cell_above_good,
    input  wire logic powerfail_sense_in,
    // Host side
    input  wire logic manual_reset_n,
    input  wire logic watchdog_kick,
    input  wire logic ce_in_n,
    // Outputs
    output logic      reset_n,
    output logic      reset_hi,
    output logic      watchdog_fault_n,
    output logic      ce_out_n,
    output logic      backup_path_active,
    output logic      backup_cell_good,
    output logic      powerfail_flag_n,
    output logic      early_supply_warning_n
);
    import ssw_pkg::*;

    // ****************************************************************
    // Reset generation
    // ****************************************************************
    wire rst_cause = !manual_reset_n || !vcc_above_reset;
    wire stretch_done;
    logic reset_n_reg;
    logic reset_n_next;

    ssw_interval #(.LIMIT(int'(STRETCH_CYC))) u_stretch (
        .mclk (mclk),
        .rst  (rst),
        .clr  (rst_cause),
        .run  (1'b1),
        .done (stretch_done)
    );

    assign reset_n_next = !rst_cause && stretch_done;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reset_n_reg <= RST_N_INIT;
        end else begin
            reset_n_reg <= reset_n_next;
        end
    end
    assign reset_n  = reset_n_reg;
    assign reset_hi = !reset_n_reg;

    // ****************************************************************
    // Watchdog
    // ****************************************************************
    logic kick_reg;
    logic wdog_n_reg;
    logic wdog_n_next;
    wire  kick_edge = (watchdog_kick != kick_reg);
    wire  wdog_clr  = !reset_n_reg || kick_edge;
    wire  wdog_expired;

    ssw_interval #(.LIMIT(int'(WDOG_CYC))) u_wdog (
        .mclk (mclk),
        .rst  (rst),
        .clr  (wdog_clr),
        .run  (1'b1),
        .done (wdog_expired)
    );

    assign wdog_n_next = wdog_clr ? 1'b1 : (wdog_expired ? 1'b0 : wdog_n_reg);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            kick_reg   <= 1'b0;
            wdog_n_reg <= WDOG_N_INIT;
        end else begin
            kick_reg   <= watchdog_kick;
            wdog_n_reg <= wdog_n_next;
        end
    end
    // Supply state overrides the timer
    assign watchdog_fault_n = !vcc_above_switchover ? 1'b0 :
                              (!vcc_above_reset ? 1'b1 : wdog_n_reg);

    // ****************************************************************
    // Chip-select gating
    // ****************************************************************
    ssw_ce_state_t ce_state_reg;
    ssw_ce_state_t ce_state_next;
    wire ce_hold_done;

    ssw_interval #(.LIMIT(int'(CE_CYC))) u_ce (
        .mclk (mclk),
        .rst  (rst),
        .clr  (ce_state_reg != SSW_CE_HOLD),
        .run  (1'b1),
        .done (ce_hold_done)
    );

    always_comb begin
        ce_state_next = ce_state_reg;
        case (ce_state_reg)
            SSW_CE_PASS: begin
                if (!reset_n_next) begin
                    ce_state_next = ce_in_n ? SSW_CE_BLOCK : SSW_CE_HOLD;
                end
            end
            SSW_CE_HOLD: begin
                if (ce_in_n || ce_hold_done) begin
                    ce_state_next = SSW_CE_BLOCK;
                end
            end
            SSW_CE_BLOCK: begin
                if (reset_n_next) begin
                    ce_state_next = SSW_CE_PASS;
                end
            end
            default: ce_state_next = SSW_CE_BLOCK;
        endcase
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ce_state_reg <= SSW_CE_BLOCK;
        end else begin
            ce_state_reg <= ce_state_next;
        end
    end
    assign ce_out_n = (ce_state_reg == SSW_CE_BLOCK) ? CE_OUT_INIT : ce_in_n;

    // ****************************************************************
    // Supply switchover and status
    // ****************************************************************
    logic backup_reg;
    wire  to_main   = vcc_above_reset || vcc_above_cell;
    wire  to_backup = !vcc_above_switchover && !vcc_above_cell;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            backup_reg <= BACKUP_INIT;
        end else if (to_main) begin
            backup_reg <= 1'b0;
        end else if (to_backup) begin
            backup_reg <= 1'b1;
        end
    end
    assign backup_path_active     = backup_reg;
    assign backup_cell_good       = vcc_above_switchover && cell_above_good;
    assign powerfail_flag_n       = vcc_above_switchover && powerfail_sense_in;
    assign early_supply_warning_n = vcc_above_early_supply_warning_n;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_cause_gone;
        $fell(rst_cause);
    endsequence
    a_reset_held: assert property (@(posedge mclk) disable iff (rst)
        rst_cause |=> !reset_n) else $error("reset released during cause");
    a_reset_stretch: assert property (@(posedge mclk) disable iff (rst)
        s_cause_gone |-> !reset_n [*8]) else $error("stretch too short");
    a_reset_inverse: assert property (@(posedge mclk) disable iff (rst)
        reset_hi == !reset_n) else $error("reset outputs not inverse");
    a_stretch_restart: assert property (@(posedge mclk) disable iff (rst)
        rst_cause |=> !stretch_done) else $error("stretch not restarted by cause");
    a_wdog_expire: assert property (@(posedge mclk) disable iff (rst)
        $rose(wdog_expired) && vcc_above_reset && !wdog_clr ##1 vcc_above_reset |-> !watchdog_fault_n)
        else $error("fault missed on timeout");
    a_wdog_kick: assert property (@(posedge mclk) disable iff (rst)
        kick_edge && vcc_above_switchover ##1 vcc_above_switchover |-> watchdog_fault_n)
        else $error("kick did not clear fault");
    a_wdog_cleared: assert property (@(posedge mclk) disable iff (rst)
        !reset_n |=> !wdog_expired) else $error("watchdog counted during reset");
    a_wdog_band: assert property (@(posedge mclk) disable iff (rst)
        vcc_above_switchover && !vcc_above_reset |-> watchdog_fault_n) else $error("fault not high in band");
    a_wdog_low_supply: assert property (@(posedge mclk) disable iff (rst)
        !vcc_above_switchover |-> !watchdog_fault_n) else $error("fault not low below switchover");
    sequence s_ce_expired;
        ce_state_reg == SSW_CE_HOLD && ce_hold_done;
    endsequence
    a_ce_gate: assert property (@(posedge mclk) disable iff (rst)
        !ce_out_n |-> !ce_in_n && (reset_n || ce_state_reg == SSW_CE_HOLD))
        else $error("chip-select low without input");
    a_ce_hold: assert property (@(posedge mclk) disable iff (rst)
        ce_state_reg == SSW_CE_HOLD && ce_in_n |=> ce_out_n) else $error("hold outlived input");
    a_ce_hold_limit: assert property (@(posedge mclk) disable iff (rst)
        s_ce_expired |=> ce_out_n) else $error("hold outlived its time");
    a_backup_main: assert property (@(posedge mclk) disable iff (rst)
        vcc_above_reset || vcc_above_cell |=> !backup_path_active) else $error("main supply not chosen");
    a_backup_cell: assert property (@(posedge mclk) disable iff (rst)
        !vcc_above_switchover && !vcc_above_cell |=> backup_path_active) else $error("cell not chosen");
    a_cell_good_low: assert property (@(posedge mclk) disable iff (rst)
        !vcc_above_switchover |-> !backup_cell_good) else $error("cell good high below switchover");
    a_early_warn: assert property (@(posedge mclk) disable iff (rst)
        !vcc_above_early_supply_warning_n |-> !early_supply_warning_n) else $error("early warning missed");
    a_pf_flag: assert property (@(posedge mclk) disable iff (rst)
        !powerfail_sense_in |-> !powerfail_flag_n) else $error("power-fail flag high on trip");
endmodule

/* File: tb/ssw_host.sv */
`timescale 1ns/10ps
module ssw_host (
    // Clock
    input  wire logic mclk,
    // Bench control
    input  wire logic kick_en,
    input  wire logic mr_req_n,
    input  wire logic wd_link,
    input  wire logic fault_n,
    // Toward the supervisor
    output logic      watchdog_kick,
    output logic      manual_reset_n
);
    logic [3:0] cnt_reg  = 4'h0;
    logic       kick_reg = 1'b0;
    // Firmware kicks every 16 cycles while alive
    always @(negedge mclk) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (kick_en && cnt_reg == 4'hf) begin
            kick_reg <= ~kick_reg;
        end
    end
    assign watchdog_kick  = kick_reg;
    assign manual_reset_n = mr_req_n & (fault_n | ~wd_link);
endmodule

/* File: tb/test_ssw_supervisor.sv */
`timescale 1ns/10ps
module test_ssw_supervisor;
    import ssw_pkg::*;
    logic mclk, rst, va_rst, va_sw, va_cell, va_low, cell_ok, pf_in, ce_in_n;
    logic kick_en, mr_req_n, wd_link, kick, mr_n;
    logic reset_n, reset_hi, fault_n, ce_out_n, backup, good, pf_n, warn_n;
    int   n_mismatch = 0;
    int   n_compared = 0;
    int   n;
    ssw_supervisor #(.STRETCH_CYC(20), .WDOG_CYC(50), .CE_CYC(5)) uut (
        .mclk(mclk), .rst(rst), .vcc_above_reset(va_rst), .vcc_above_switchover(va_sw),
        .vcc_above_cell(va_cell), .vcc_above_early_supply_warning_n(va_low), .cell_above_good(cell_ok),
        .powerfail_sense_in(pf_in), .manual_reset_n(mr_n), .watchdog_kick(kick), .ce_in_n(ce_in_n),
        .reset_n(reset_n), .reset_hi(reset_hi), .watchdog_fault_n(fault_n), .ce_out_n(ce_out_n),
        .backup_path_active(backup), .backup_cell_good(good), .powerfail_flag_n(pf_n),
        .early_supply_warning_n(warn_n));
    ssw_host host (.mclk(mclk), .kick_en(kick_en), .mr_req_n(mr_req_n), .wd_link(wd_link),
        .fault_n(fault_n), .watchdog_kick(kick), .manual_reset_n(mr_n));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    function automatic logic sig(input int sel);
        return sel == 0 ? reset_n : (sel == 1 ? fault_n : ce_out_n);
    endfunction
    // Bounded wait for a level; n holds the cycles spent
    task automatic wt(input int sel, input logic v);
        for (n = 0; n < 200 && sig(sel) !== v; n++)
            @(negedge mclk);
        if (n == 200) begin
            n_mismatch++;
            results();
        end
    endtask
    task automatic t_manual();
        mr_req_n = 1'b0;
        repeat (3) @(negedge mclk);
        chk(reset_n, 1'b0);
        chk(reset_hi, 1'b1);
        mr_req_n = 1'b1;
        wt(0, 1'b1);
        chk(n >= 19 && n <= 23, 1'b1);
        chk(reset_hi, 1'b0);
        $display("manual reset done");
    endtask
    task automatic t_brown();
        va_rst = 1'b0;
        repeat (2) @(negedge mclk);
        chk(reset_n, 1'b0);
        va_rst = 1'b1;
        repeat (12) @(negedge mclk);
        va_rst = 1'b0;
        @(negedge mclk);
        va_rst = 1'b1;
        wt(0, 1'b1);
        chk(n >= 19 && n <= 23, 1'b1);
        $display("brownout done");
    endtask
    task automatic t_ce();
        ce_in_n = 1'b0;
        @(negedge mclk);
        chk(ce_out_n, 1'b0);
        mr_req_n = 1'b0;
        wt(2, 1'b1);
        chk(n >= 3 && n <= 7, 1'b1);
        ce_in_n = 1'b1;
        mr_req_n = 1'b1;
        wt(0, 1'b1);
        $display("chip select done");
    endtask
    task automatic t_wdog();
        kick_en = 1'b0;
        wt(1, 1'b0);
        chk(n >= 35 && n <= 56, 1'b1);
        kick_en = 1'b1;
        wt(1, 1'b1);
        chk(n <= 18, 1'b1);
        kick_en = 1'b0;
        wd_link = 1'b1;
        wt(1, 1'b0);
        wt(0, 1'b0);
        chk(n <= 3, 1'b1);
        wt(1, 1'b1);
        chk(n <= 3, 1'b1);
        kick_en = 1'b1;
        wd_link = 1'b0;
        wt(0, 1'b1);
        $display("watchdog done");
    endtask
    task automatic t_levels();
        va_low = 1'b0;
        pf_in = 1'b0;
        cell_ok = 1'b0;
        @(negedge mclk);
        chk(warn_n, 1'b0);
        chk(pf_n, 1'b0);
        chk(good, 1'b0);
        pf_in = 1'b1;
        cell_ok = 1'b1;
        va_rst = 1'b0;
        repeat (2) @(negedge mclk);
        chk(fault_n, 1'b1);
        chk(good, 1'b1);
        chk(pf_n, 1'b1);
        va_sw = 1'b0;
        va_cell = 1'b0;
        repeat (2) @(negedge mclk);
        chk(fault_n, 1'b0);
        chk(good | pf_n, 1'b0);
        chk(backup, 1'b1);
        {va_sw, va_cell, va_rst, va_low} = 4'hf;
        repeat (2) @(negedge mclk);
        chk(backup, 1'b0);
        chk(warn_n, 1'b1);
        wt(0, 1'b1);
        $display("levels done");
    endtask
    initial begin
        {rst, va_rst, va_sw, va_cell, va_low, cell_ok, pf_in} = 7'h7f;
        {ce_in_n, kick_en, mr_req_n, wd_link} = 4'he;
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        chk(reset_n, 1'b0);
        wt(0, 1'b1);
        t_manual();
        t_brown();
        t_ce();
        t_wdog();
        t_levels();
        results();
    end
endmodule
